// ### design/dai_status_pkg.sv
/*
  Shared constants for the audio transceiver status register and its reset
  sequencer: field positions, reset values, reset timing and sequencer states.
  Assumes clk of the status logic is the internal oscillator clock.
*/
package dai_status_pkg;
  // first status byte fields
  localparam int unsigned CS_CONSUMER_BIT  = 0;
  localparam int unsigned PLL_LOCKED_BIT   = 1;
  localparam int unsigned VALIDITY_OK_BIT  = 2;
  localparam int unsigned PARITY_OK_BIT    = 3;
  localparam int unsigned BIPHASE_OK_BIT   = 4;
  localparam int unsigned OVERRUN_OK_BIT   = 5;
  localparam int unsigned CS_STABLE_BIT    = 6;
  localparam int unsigned DIRECTION_BIT    = 7;
  localparam int unsigned ERROR_BITS       = 7;
  // second status byte fields
  localparam int unsigned MUTE_OFF_BIT     = 0;
  localparam int unsigned LINE_OUT_OFF_BIT = 1;
  localparam int unsigned HIGH_SENS_BIT    = 2;
  localparam int unsigned SER_OUT_OFF_BIT  = 3;
  localparam int unsigned SOURCE_LINE_BIT  = 4;
  localparam int unsigned RATIO_256_BIT    = 5;
  localparam int unsigned CS_BIT7_INV_BIT  = 6;
  localparam int unsigned CS_BIT6_INV_BIT  = 7;
  localparam int unsigned CFG_BITS         = 6;
  // reset values
  localparam logic [7:0] STATUS_RESET      = 8'hff;
  localparam logic [5:0] CFG_RESET         = 6'h3f;
  // serial word: two bytes, bit 0 of the first byte sent first
  localparam int unsigned STATUS_WORD_BITS = 16;
  localparam logic [4:0]  FIRST_BYTE_DONE  = 5'h08;
  localparam logic [4:0]  WORD_DONE        = 5'h10;
  // internal synchronous reset length, in oscillator periods
  localparam int unsigned RESET_PERIODS    = 3;
  localparam logic [1:0]  RESET_LAST       = 2'(RESET_PERIODS - 1);

  // reset sequencer, gray along run, pulse, wait, hold
  typedef enum logic [1:0] {
    ST_RUN      = 2'b00,
    ST_PULSE    = 2'b01,
    ST_WAIT_OSC = 2'b11,
    ST_HOLD     = 2'b10
  } reset_state_t;
endpackage

// ### design/sync2.sv
/*
  Two flip-flop level synchroniser, parameterised in width.
  Assumes each bit is an independent level; no word coherence implied.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_meta     = sys_rst ? INIT : async_in;
    next_sync_out = sys_rst ? INIT : meta;
  end

  always_ff @(posedge clk) begin
    meta     <= next_meta;
    sync_out <= next_sync_out;
  end
endmodule

// ### design/dai_status_reset.sv
/*
  Status register pair and reset sequencer of a digital audio transceiver,
  with the serial read-out toward the host on the host's own clock.
  Assumes clk is the internal oscillator; the host raises the status select
  at least two clk periods before its first serial clock edge.
*/
// Function
// (R1) both status bytes all ones after reset
// (R2) error bits drop, return only after read
// (R3) bit 7 shows applied transmit/receive direction
// (R4) bit 0 reports professional versus consumer
// (R5) bit 1 reports clock loop lock state
// (R6) bits 2-5 flag validity, parity, biphase, overrun
// (R7) bit 6 flags channel status change
// (R8) second byte 0,1,3 show enables active low
// (R9) second byte bit 2 shows line input
// (R10) second byte bit 4 shows output source
// (R11) second byte bit 5 shows clock ratio
// (R12) second byte 6,7 invert channel status bits
// (R13) reset runs on internal oscillator only
// (R14) short reset pulse starts the oscillator
// (R15) internal synchronous reset lasts three periods
// (R16) reset starts after pulse and oscillator ready
// (R17) config pins read only after reset ends
// (R18) running oscillator means zero startup delay
// (R19) status shifted out bit 0 first
// (R20) control bits and pins combined active low
// (R21) error during read is kept after clear
`timescale 1ns/1ps
module dai_status_reset (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       reset_input,
  input  wire logic       power_down_input,
  input  wire logic       osc_running,
  output logic            osc_enable,
  output logic            internal_reset,
  output logic            device_ready,
  input  wire logic       cs_professional,
  input  wire logic       pll_unlocked,
  input  wire logic       validity_error,
  input  wire logic       parity_error,
  input  wire logic       biphase_error,
  input  wire logic       user_overrun,
  input  wire logic       cs_changed,
  input  wire logic       active_transmit,
  input  wire logic [5:0] control_byte2,
  input  wire logic       audio_mute_pin,
  input  wire logic       line_output_enable_pin,
  input  wire logic       line_input_select_pin,
  input  wire logic       serial_audio_output_enable_pin,
  input  wire logic       serial_source_select_pin,
  input  wire logic       clock_ratio_select,
  input  wire logic       cs_mode_bit6,
  input  wire logic       cs_mode_bit7,
  input  wire logic       host_serial_clock,
  input  wire logic       host_status_select,
  output logic            host_serial_data_line_out,
  output logic            host_serial_data_line_oe,
  output logic [7:0]      error_and_mode_status,
  output logic [7:0]      configuration_readback_status
);
  localparam int unsigned PIN_BITS = 9;

  dai_status_pkg::reset_state_t state;
  dai_status_pkg::reset_state_t next_state;
  logic [1:0]          hold_cnt;
  logic [1:0]          next_hold_cnt;
  logic [PIN_BITS-1:0] pins_raw;
  logic [PIN_BITS-1:0] pins_s;
  logic [5:0]          cfg_pins;
  logic [5:0]          next_cfg_pins;
  logic                reset_req;
  logic                osc_s;
  logic [6:0]          cond;
  logic [7:0]          next_byte1;
  logic [7:0]          next_byte2;
  logic [7:0]          snap1;
  logic [7:0]          snap2;
  logic [7:0]          next_snap1;
  logic [7:0]          next_snap2;
  logic                sel_s;
  logic                read_tog_s;
  logic                read_tog_seen;
  logic                next_read_tog_seen;
  logic                read_pulse;
  // link domain
  logic [4:0]          bit_idx;
  logic [4:0]          next_bit_idx;
  logic                next_data_out;
  logic                read_tog;
  logic                next_read_tog;
  logic [15:0]         snap_word;

  // pins arrive from outside; reset pins idle low, config pins idle high
  assign pins_raw = {osc_running, power_down_input, reset_input,
                     clock_ratio_select, serial_source_select_pin,
                     serial_audio_output_enable_pin, line_input_select_pin,
                     line_output_enable_pin, audio_mute_pin};

  sync2 #(
    .WIDTH (PIN_BITS),
    .INIT  (9'h03f)
  ) u_pin_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  sync2 #(
    .WIDTH (2),
    .INIT  (2'h0)
  ) u_link_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({read_tog, host_status_select}),
    .sync_out ({read_tog_s, sel_s})
  );

  assign reset_req = pins_s[6] | pins_s[7];
  assign osc_s     = pins_s[8];

  // reset sequencer, clocked by the internal oscillator
  always_comb begin
    next_state    = state;
    next_hold_cnt = 2'h0;
    case (state)
      dai_status_pkg::ST_RUN: begin
        if (reset_req) begin
          next_state = dai_status_pkg::ST_PULSE;
        end
      end
      dai_status_pkg::ST_PULSE: begin
        // (R16) start after falling edge
        // (R18) running oscillator skips wait
        if (!reset_req) begin
          next_state = osc_s ? dai_status_pkg::ST_HOLD : dai_status_pkg::ST_WAIT_OSC;
        end
      end
      dai_status_pkg::ST_WAIT_OSC: begin
        // (R16) wait for oscillator startup
        if (reset_req) begin
          next_state = dai_status_pkg::ST_PULSE;
        end else if (osc_s) begin
          next_state = dai_status_pkg::ST_HOLD;
        end
      end
      dai_status_pkg::ST_HOLD: begin
        // (R15) three period reset
        next_hold_cnt = hold_cnt + 2'h1;
        if (reset_req) begin
          next_state = dai_status_pkg::ST_PULSE;
        end else if (hold_cnt == dai_status_pkg::RESET_LAST) begin
          next_state = dai_status_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = dai_status_pkg::ST_WAIT_OSC;
      end
    endcase
    if (sys_rst) begin
      next_state    = dai_status_pkg::ST_WAIT_OSC;
      next_hold_cnt = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    state    <= next_state;
    hold_cnt <= next_hold_cnt;
  end

  // (R13) (R14) oscillator kept on until reset is through
  assign osc_enable     = (state != dai_status_pkg::ST_RUN);
  assign internal_reset = (state != dai_status_pkg::ST_RUN);
  assign device_ready   = (state == dai_status_pkg::ST_RUN);

  // (R17) pins ignored until reset done
  always_comb begin
    next_cfg_pins = cfg_pins;
    if (sys_rst) begin
      next_cfg_pins = dai_status_pkg::CFG_RESET;
    end else if (!internal_reset) begin
      next_cfg_pins = pins_s[5:0];
    end
  end

  always_ff @(posedge clk) begin
    cfg_pins <= next_cfg_pins;
  end

  // read completion arrives as a toggle from the link domain
  assign read_pulse = read_tog_s ^ read_tog_seen;

  always_comb begin
    next_read_tog_seen = sys_rst ? 1'b0 : read_tog_s;
  end

  always_ff @(posedge clk) begin
    read_tog_seen <= next_read_tog_seen;
  end

  // (R4) (R5) (R6) (R7) error conditions, active high
  assign cond = {cs_changed, user_overrun, biphase_error, parity_error,
                 validity_error, pll_unlocked, cs_professional};

  always_comb begin
    next_byte1 = error_and_mode_status;
    next_byte2 = configuration_readback_status;
    // (R2) (R21) clear only what the host saw low
    next_byte1[6:0] = (error_and_mode_status[6:0] |
                       (read_pulse ? ~snap1[6:0] : 7'h00)) & ~cond;
    // (R3) applied direction
    next_byte1[dai_status_pkg::DIRECTION_BIT] = active_transmit;
    // (R20) (R8) (R9) (R10) (R11) zero from either source wins
    next_byte2[5:0] = control_byte2 & cfg_pins;
    // (R12) inverted mode bits
    next_byte2[dai_status_pkg::CS_BIT7_INV_BIT] = ~cs_mode_bit7;
    next_byte2[dai_status_pkg::CS_BIT6_INV_BIT] = ~cs_mode_bit6;
    // (R1) all ones through any reset
    if (sys_rst || internal_reset) begin
      next_byte1 = dai_status_pkg::STATUS_RESET;
      next_byte2 = dai_status_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge clk) begin
    error_and_mode_status         <= next_byte1;
    configuration_readback_status <= next_byte2;
  end

  // snapshot frozen while the host reads, so the link sees a stable word
  always_comb begin
    next_snap1 = snap1;
    next_snap2 = snap2;
    if (sys_rst) begin
      next_snap1 = dai_status_pkg::STATUS_RESET;
      next_snap2 = dai_status_pkg::STATUS_RESET;
    end else if (!sel_s) begin
      next_snap1 = error_and_mode_status;
      next_snap2 = configuration_readback_status;
    end
  end

  always_ff @(posedge clk) begin
    snap1 <= next_snap1;
    snap2 <= next_snap2;
  end

  assign snap_word = {snap2, snap1};

  // link side: the host clock stops between frames, so the frame select
  // itself clears the bit counter
  always_comb begin
    next_bit_idx  = bit_idx;
    next_data_out = host_serial_data_line_out;
    if (bit_idx < dai_status_pkg::WORD_DONE) begin
      // (R19) lowest bit first
      next_data_out = snap_word[bit_idx[3:0]];
      next_bit_idx  = bit_idx + 5'h01;
    end
  end

  always_ff @(posedge host_serial_clock or negedge host_status_select) begin
    if (!host_status_select) begin
      bit_idx                   <= 5'h00;
      host_serial_data_line_out <= 1'b1;
    end else begin
      bit_idx                   <= next_bit_idx;
      host_serial_data_line_out <= next_data_out;
    end
  end

  // (R2) first byte out counts as a read
  always_comb begin
    next_read_tog = read_tog;
    if (bit_idx == dai_status_pkg::FIRST_BYTE_DONE - 5'h01) begin
      next_read_tog = ~read_tog;
    end
  end

  // link clock may be idle during reset, so reset acts without it
  always_ff @(posedge host_serial_clock or posedge sys_rst) begin
    if (sys_rst) begin
      read_tog <= 1'b0;
    end else begin
      read_tog <= next_read_tog;
    end
  end

  assign host_serial_data_line_oe = host_status_select;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_reset_ones;
    internal_reset |=> (error_and_mode_status == 8'hff) &&
                       (configuration_readback_status == 8'hff);
  endproperty
  a_reset_ones: assert property (p_reset_ones) else $error("status not all ones in reset"); // R1

  property p_error_drops;
    (!internal_reset && (cond != 7'h00)) |=>
      ((error_and_mode_status[6:0] & $past(cond)) == 7'h00) || internal_reset;
  endproperty
  a_error_drops: assert property (p_error_drops) else $error("error bit did not drop"); // R2

  property p_return_needs_read;
    (!internal_reset && !read_pulse) |=>
      internal_reset || $past(internal_reset) ||
      ((error_and_mode_status[6:0] & ~$past(error_and_mode_status[6:0])) == 7'h00);
  endproperty
  a_return_needs_read: assert property (p_return_needs_read) else $error("bit rose without read"); // R2

  property p_direction;
    !internal_reset |=> internal_reset ||
      (error_and_mode_status[7] == $past(active_transmit));
  endproperty
  a_direction: assert property (p_direction) else $error("direction bit wrong"); // R3

  property p_combined_cfg;
    !internal_reset |=> internal_reset ||
      (configuration_readback_status[5:0] == ($past(control_byte2) & $past(cfg_pins)));
  endproperty
  a_combined_cfg: assert property (p_combined_cfg) else $error("config readback wrong"); // R20

  property p_mode_bits;
    !internal_reset |=> internal_reset ||
      (configuration_readback_status[7:6] == ~{$past(cs_mode_bit6), $past(cs_mode_bit7)});
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode bits not inverted"); // R12

  property p_hold_len;
    $rose(state == dai_status_pkg::ST_HOLD) && !reset_req |->
      ((state == dai_status_pkg::ST_HOLD) && !reset_req)[*3] ##1 device_ready;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("reset hold not three periods"); // R15

  property p_zero_osc_delay;
    (state == dai_status_pkg::ST_PULSE && !reset_req && osc_s) |=>
      state == dai_status_pkg::ST_HOLD;
  endproperty
  a_zero_osc_delay: assert property (p_zero_osc_delay) else $error("waited on running osc"); // R18

  property p_wait_osc;
    (state == dai_status_pkg::ST_WAIT_OSC && !osc_s && !reset_req) |=> $stable(state);
  endproperty
  a_wait_osc: assert property (p_wait_osc) else $error("reset left before osc start"); // R16

  property p_pins_frozen;
    internal_reset |=> cfg_pins == $past(cfg_pins);
  endproperty
  a_pins_frozen: assert property (p_pins_frozen) else $error("pins read during reset"); // R17

  property p_keep_late_error;
    (read_pulse && !internal_reset) |=> internal_reset ||
      (($past(snap1[6:0]) & ~$past(error_and_mode_status[6:0]) &
        error_and_mode_status[6:0]) == 7'h00);
  endproperty
  a_keep_late_error: assert property (p_keep_late_error) else $error("late error lost"); // R21

  property p_lsb_first;
    @(posedge host_serial_clock) disable iff (sys_rst)
      (host_status_select && bit_idx == 5'h00) |=> host_serial_data_line_out == $past(snap1[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first bit not bit 0"); // R19

  c_read_clear: cover property (read_pulse ##1 error_and_mode_status[6:0] == 7'h7f);
  c_reset_done: cover property ($fell(internal_reset));
  c_osc_wait: cover property (state == dai_status_pkg::ST_WAIT_OSC ##[1:20] device_ready);
endmodule

// ### testbench/host_model.sv
/*
  Host side of the serial status link: frames a read and collects bits.
  Assumes the device shifts one bit per rising link clock edge.
*/
`timescale 1ns/1ps
module host_model (
  output logic     host_serial_clock,
  output logic     host_status_select,
  input  wire logic host_serial_data_line_out,
  input  wire logic host_serial_data_line_oe
);
  initial begin
    host_serial_clock  = 1'b0;
    host_status_select = 1'b0;
  end

  // link clock stands still outside frames; odd offset keeps phase unrelated
  task automatic read_word(input int nbits, output logic [15:0] word);
    word = 16'h0000;
    #13.7;
    host_status_select = 1'b1;
    #40;
    for (int k = 0; k < nbits; k++) begin
      host_serial_clock = 1'b1;
      #62.5;
      host_serial_clock = 1'b0;
      word[k] = host_serial_data_line_oe ? host_serial_data_line_out : 1'bx;
      #62.5;
    end
    host_status_select = 1'b0;
    #40;
  endtask
endmodule

// ### testbench/tb_top.sv
/*
  Self-checking bench for the status register pair and reset sequencer.
  Assumes clk is the oscillator clock; the host model owns the link clock.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        sys_rst;
  logic        reset_input;
  logic        power_down_input;
  logic        osc_running;
  logic        osc_enable;
  logic        internal_reset;
  logic        device_ready;
  logic [6:0]  cond;
  logic        active_transmit;
  logic [5:0]  ctrl;
  logic [5:0]  pins;
  logic        cs6;
  logic        cs7;
  logic        sclk;
  logic        sel;
  logic        sdo;
  logic        sdo_oe;
  logic [7:0]  byte1;
  logic [7:0]  byte2;
  logic [15:0] w;
  int          bad_count;
  int          comparisons;
  int          n;
  int          nb;
  int          exp_n;
  logic [6:0]  dropped;
  logic [6:0]  v;
  logic [15:0] exp_word;

  dai_status_reset dut (
    .clk(clk), .sys_rst(sys_rst), .reset_input(reset_input),
    .power_down_input(power_down_input), .osc_running(osc_running),
    .osc_enable(osc_enable), .internal_reset(internal_reset), .device_ready(device_ready),
    .cs_professional(cond[0]), .pll_unlocked(cond[1]), .validity_error(cond[2]),
    .parity_error(cond[3]), .biphase_error(cond[4]), .user_overrun(cond[5]),
    .cs_changed(cond[6]), .active_transmit(active_transmit), .control_byte2(ctrl),
    .audio_mute_pin(pins[0]), .line_output_enable_pin(pins[1]),
    .line_input_select_pin(pins[2]), .serial_audio_output_enable_pin(pins[3]),
    .serial_source_select_pin(pins[4]), .clock_ratio_select(pins[5]),
    .cs_mode_bit6(cs6), .cs_mode_bit7(cs7), .host_serial_clock(sclk),
    .host_status_select(sel), .host_serial_data_line_out(sdo),
    .host_serial_data_line_oe(sdo_oe), .error_and_mode_status(byte1),
    .configuration_readback_status(byte2)
  );

  host_model host (
    .host_serial_clock(sclk), .host_status_select(sel),
    .host_serial_data_line_out(sdo), .host_serial_data_line_oe(sdo_oe)
  );

  always #2 clk = ~clk;

  function automatic logic [7:0] exp_b1(input logic [6:0] dropped);
    return {active_transmit, ~dropped};
  endfunction

  function automatic logic [7:0] exp_b2();
    return {~cs6, ~cs7, ctrl & pins};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // bytes must read all ones for as long as the sequencer holds reset
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (device_ready !== 1'b1 && cnt < 60) begin
      @(posedge clk);
      #1;
      cnt++;
      if (device_ready !== 1'b1) begin
        chk({byte2, byte1}, 16'hffff, "held in reset");
        chk({15'h0000, osc_enable}, 16'h0001, "osc request");
      end
    end
  endtask

  task automatic pulse_cond(input logic [6:0] v);
    @(posedge clk);
    cond            <= v;
    active_transmit <= 1'($urandom);
    ctrl            <= 6'($urandom);
    pins            <= 6'($urandom);
    cs6             <= 1'($urandom);
    cs7             <= 1'($urandom);
    @(posedge clk);
    cond <= 7'h00;
  endtask

  task automatic reset_seq(input bit pd, input bit osc);
    @(posedge clk);
    osc_running <= osc;
    cs6         <= 1'b0;
    cs7         <= 1'b0;
    if (pd) power_down_input <= 1'b1;
    else reset_input <= 1'b1;
    cyc(3);
    power_down_input <= 1'b0;
    reset_input      <= 1'b0;
    cond             <= 7'h7f;
    ctrl             <= 6'($urandom);
    @(posedge clk);
    cond <= 7'h00;
    if (!osc) begin
      cyc(8);
      #1;
      chk({15'h0000, internal_reset}, 16'h0001, "waits for osc");
      @(posedge clk);
      osc_running <= 1'b1;
    end
    wait_ready(n);
    // two sync edges ahead of the hold; a late oscillator counts one edge more
    exp_n = dai_status_pkg::RESET_PERIODS + (osc ? 2 : 3);
    chk({15'h0000, 1'(n == exp_n)}, 16'h0001, "reset length");
    cyc(6);
    #1;
    chk({byte2, byte1}, {exp_b2(), exp_b1(7'h00)}, "after reset");
    chk({15'h0000, osc_enable}, 16'h0000, "osc released");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #300us;
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    clk = 1'b0; sys_rst = 1'b1; reset_input = 1'b0; power_down_input = 1'b0;
    // direction reads transmit after reset, as active_transmit starts high
    osc_running = 1'b1; cond = 7'h00; active_transmit = 1'b1; dropped = 7'h00;
    ctrl = 6'h3f; pins = 6'h3f; cs6 = 1'b0; cs7 = 1'b0;
    bad_count = 0; comparisons = 0;
    n = $urandom(32'h535d_cfea);
    cyc(20);
    sys_rst <= 1'b0;
    wait_ready(n);
    #1;
    chk({byte2, byte1}, 16'hffff, "power-on value");
    host.read_word(16, w);
    chk(w, 16'hffff, "power-on serial word");
    // walk each error bit, then random mixes; each pass ends in a host read
    for (int k = 0; k < 13; k++) begin
      v = (k < 7) ? 7'(1 << k) : 7'($urandom);
      pulse_cond(v);
      dropped = dropped | v;
      cyc(4);
      #1;
      chk({8'h00, byte1}, {8'h00, exp_b1(dropped)}, "first byte");
      chk({8'h00, byte2}, {8'h00, exp_b2()}, "second byte");
      nb = ($urandom % 2 == 0) ? 8 : 16;
      exp_word = {exp_b2(), exp_b1(dropped)};
      host.read_word(nb, w);
      chk(w, (nb == 8) ? {8'h00, exp_word[7:0]} : exp_word, "serial word");
      chk({14'h0000, sdo_oe, sdo}, 16'h0001, "idle line");
      dropped = 7'h00;
      cyc(1);
      #1;
      chk({8'h00, byte1}, {8'h00, exp_b1(dropped)}, "cleared by read");
    end
    // flag raised after the snapshot but before the clear must survive
    exp_word = {exp_b2(), exp_b1(7'h00)};
    fork
      host.read_word(8, w);
      begin
        cyc(20);
        pulse_cond(7'h08);
      end
    join
    chk(w, {8'h00, exp_word[7:0]}, "word frozen at select");
    cyc(1);
    #1;
    chk({8'h00, byte1}, {8'h00, exp_b1(7'h08)}, "late error kept");
    reset_seq(1'b0, 1'b1);
    reset_seq(1'b1, 1'b1);
    reset_seq(1'b0, 1'b0);
    exp_word = {exp_b2(), exp_b1(7'h00)};
    host.read_word(16, w);
    chk(w, exp_word, "serial word after reset");
    end_sim();
  end
endmodule
